// [floppy_logical_device_config.sv]
// Floppy logical device configuration registers with pin steering
`timescale 1ns/1ns
`include "floppy_cfg_regs.svh"

// Operation
// - Registers return to defaults only on main or standby power-on or host bus reset.
// - A soft reset leaves both configuration registers unchanged.
// - Mode bit 0 selects normal or enhanced mode two floppy operation.
// - Mode bit 1 selects burst DMA when zero, non-burst when one.
// - Mode bits 3:2 select interface compatibility mode; code 10 reserved.
// - Mode bit 4 swaps drive 0 and drive 1 select and motor outputs.
// - Mode bit 6 chooses open drain when zero, push-pull when one.
// - Mode bit 7 set places every floppy output in high impedance.
// - Forced write protect asserts core write protect whenever a drive is selected.
// - Option bits 3:2 leave density normal, or force it to one or zero.
module floppy_logical_device_config (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic standby_supply_por_n,
  input wire logic host_bus_reset_n,
  input wire logic soft_reset,
  // Configuration port, already decoded from the host bus
  input wire logic device_selected,
  input wire logic port_write,
  input wire logic port_read,
  input wire logic port_data_sel,
  input wire logic [7:0] port_wdata,
  output logic [7:0] port_rdata,
  // Controller core side
  input wire logic core_drive0_select_n,
  input wire logic core_drive1_select_n,
  input wire logic core_motor0_enable_n,
  input wire logic core_motor1_enable_n,
  input wire logic core_density,
  output floppy_cfg_pkg::core_cfg_s core_cfg,
  output logic core_write_protect_n,
  // Drive interface pins
  input wire logic write_protect_n,
  output logic drive0_select_n,
  output logic drive1_select_n,
  output logic motor0_enable_n,
  output logic motor1_enable_n,
  output logic density,
  output logic [4:0] floppy_pin_oe
);

  floppy_cfg_pkg::cfg_state_s state;
  floppy_cfg_pkg::cfg_state_s next_state;
  logic hard_reset;
  logic index_access;
  logic data_access;
  logic [4:0] pin_level;
  logic [4:0] pin_oe;
  logic swap;
  logic [1:0] density_sel;

  // Any of the three hard reset sources restores defaults
  assign hard_reset = !reset_n || !standby_supply_por_n || !host_bus_reset_n;

  // Index and data ports of the configuration window
  assign index_access = port_data_sel == 1'b0;
  assign data_access = port_data_sel == 1'b1 && device_selected;

  // Pin values before the driver stage; the swap is pure steering
  assign swap = state.mode[`MODE_SWAP_BIT];
  assign density_sel = state.option[`OPT_DENSITY_HI:`OPT_DENSITY_LO];
  always_comb begin
    pin_level = '0;
    pin_level[`PIN_DRIVE0_SELECT] = swap ? core_drive1_select_n : core_drive0_select_n;
    pin_level[`PIN_DRIVE1_SELECT] = swap ? core_drive0_select_n : core_drive1_select_n;
    pin_level[`PIN_MOTOR0_ENABLE] = swap ? core_motor1_enable_n : core_motor0_enable_n;
    pin_level[`PIN_MOTOR1_ENABLE] = swap ? core_motor0_enable_n : core_motor1_enable_n;
    if (density_sel == `DENSITY_FORCE_ONE) begin
      pin_level[`PIN_DENSITY] = 1'b1;
    end else if (density_sel == `DENSITY_FORCE_ZERO) begin
      pin_level[`PIN_DENSITY] = 1'b0;
    end else begin
      pin_level[`PIN_DENSITY] = core_density;
    end
  end

  // Driver stage: open drain only drives low, tri-state drives nothing
  genvar g;
  generate
    for (g = 0; g < `FLOPPY_PIN_COUNT; g = g + 1) begin : gen_pin
      // Kept apart from next_state so that only one process writes the state copy
      assign pin_oe[g] = !state.mode[`MODE_TRISTATE_BIT]
        && (state.mode[`MODE_PUSH_PULL_BIT] || !pin_level[g]);
    end
  endgenerate

  // Register file, read path and core settings
  always_comb begin
    next_state.index = state.index;
    next_state.mode = state.mode;
    next_state.option = state.option;
    next_state.rdata = state.rdata;
    next_state.pins.level = pin_level;
    next_state.pins.oe = pin_oe;
    // Host writes through the index/data pair
    if (port_write && index_access) begin
      next_state.index = port_wdata;
    end else if (port_write && data_access) begin
      if (state.index == `FLOPPY_MODE_CONFIG_IDX) begin
        next_state.mode = port_wdata;
      end else if (state.index == `FLOPPY_OPTION_CONFIG_IDX) begin
        next_state.option = port_wdata;
      end
    end
    // Read data is registered one cycle after the strobe
    if (port_read && index_access) begin
      next_state.rdata = state.index;
    end else if (port_read && data_access) begin
      if (state.index == `FLOPPY_MODE_CONFIG_IDX) begin
        next_state.rdata = state.mode;
      end else if (state.index == `FLOPPY_OPTION_CONFIG_IDX) begin
        next_state.rdata = state.option;
      end else begin
        next_state.rdata = `FLOPPY_UNMAPPED_READ;
      end
    end
    next_state.core_cfg.enhanced_mode_two = state.mode[`MODE_ENHANCED_BIT];
    next_state.core_cfg.dma_non_burst = state.mode[`MODE_NON_BURST_BIT];
    next_state.core_cfg.iface_mode =
      floppy_cfg_pkg::iface_mode_e'(state.mode[`MODE_IFACE_HI:`MODE_IFACE_LO]);
    next_state.core_cfg.push_pull_driver = state.mode[`MODE_PUSH_PULL_BIT];
    next_state.core_cfg.outputs_tristate = state.mode[`MODE_TRISTATE_BIT];
    // Forced protect sees the core drive selects before any swap, i.e. either drive
    next_state.core_write_protect_n = !((state.option[`OPT_FORCE_WP_BIT]
      && (!core_drive0_select_n || !core_drive1_select_n)) || !write_protect_n);
  end

  // Soft reset is deliberately not a term here, so settings survive it
  always_ff @(posedge sys_clk) begin
    if (hard_reset) begin
      state.index <= `FLOPPY_INDEX_RST;
      state.mode <= `FLOPPY_MODE_CONFIG_RST;
      state.option <= `FLOPPY_OPTION_CONFIG_RST;
      state.rdata <= `FLOPPY_UNMAPPED_READ;
      state.core_cfg <= '0;
      state.core_write_protect_n <= 1'b1;
      state.pins.level <= '1;
      state.pins.oe <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state flops
  assign port_rdata = state.rdata;
  assign core_cfg = state.core_cfg;
  assign core_write_protect_n = state.core_write_protect_n;
  assign drive0_select_n = state.pins.level[`PIN_DRIVE0_SELECT];
  assign drive1_select_n = state.pins.level[`PIN_DRIVE1_SELECT];
  assign motor0_enable_n = state.pins.level[`PIN_MOTOR0_ENABLE];
  assign motor1_enable_n = state.pins.level[`PIN_MOTOR1_ENABLE];
  assign density = state.pins.level[`PIN_DENSITY];
  assign floppy_pin_oe = state.pins.oe;

endmodule

// [floppy_cfg_regs.svh]
// Index, field and reset constants of the floppy configuration registers
`ifndef FLOPPY_CFG_REGS_SVH
`define FLOPPY_CFG_REGS_SVH

// Register indices behind the data port
`define FLOPPY_MODE_CONFIG_IDX 8'hF0
`define FLOPPY_OPTION_CONFIG_IDX 8'hF1

// Reset values
`define FLOPPY_MODE_CONFIG_RST 8'h0E
`define FLOPPY_OPTION_CONFIG_RST 8'h00
`define FLOPPY_INDEX_RST 8'h00
`define FLOPPY_UNMAPPED_READ 8'h00

// Mode register fields
`define MODE_ENHANCED_BIT 0
`define MODE_NON_BURST_BIT 1
`define MODE_IFACE_HI 3
`define MODE_IFACE_LO 2
`define MODE_SWAP_BIT 4
`define MODE_PUSH_PULL_BIT 6
`define MODE_TRISTATE_BIT 7

// Option register fields
`define OPT_FORCE_WP_BIT 0
`define OPT_DENSITY_HI 3
`define OPT_DENSITY_LO 2

// Density select codes
`define DENSITY_FORCE_ONE 2'h2
`define DENSITY_FORCE_ZERO 2'h3

// Pin positions in the floppy output vector
`define PIN_DRIVE0_SELECT 0
`define PIN_DRIVE1_SELECT 1
`define PIN_MOTOR0_ENABLE 2
`define PIN_MOTOR1_ENABLE 3
`define PIN_DENSITY 4
`define FLOPPY_PIN_COUNT 5

`endif

// [floppy_cfg_pkg.sv]
// Types shared by the floppy configuration register block
package floppy_cfg_pkg;

  // Interface compatibility modes
  typedef enum logic [1:0] {
    iface_third = 2'h0,
    iface_second = 2'h1,
    iface_reserved = 2'h2,
    iface_compatible = 2'h3
  } iface_mode_e;

  // Settings handed to the controller core
  typedef struct packed {
    logic enhanced_mode_two;
    logic dma_non_burst;
    iface_mode_e iface_mode;
    logic push_pull_driver;
    logic outputs_tristate;
  } core_cfg_s;

  // Floppy pins: value and output enable per pin
  typedef struct packed {
    logic [4:0] level;
    logic [4:0] oe;
  } floppy_pins_s;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] mode;
    logic [7:0] option;
    logic [7:0] rdata;
    core_cfg_s core_cfg;
    logic core_write_protect_n;
    floppy_pins_s pins;
  } cfg_state_s;

endpackage

// [floppy_drive_model.sv]
// Drive stand-in answering write protect from the drive 1 select pin
`timescale 1ns/1ns
module floppy_drive_model (
  // Select pins from the block
  input wire logic drive0_select_n,
  input wire logic drive1_select_n,
  // Protect line back to the block, pulled up while drive 1 is idle
  output logic write_protect_n
);
  // Only drive 1 holds a protected disk, so drive 0 never pulls the line
  assign write_protect_n = drive1_select_n;
endmodule

// [floppy_cfg_sva.sv]
// Checker for pin steering, write protect and read port of the config block
`timescale 1ns/1ns
module floppy_cfg_sva (
  // Clock and hard resets
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic standby_supply_por_n,
  input wire logic host_bus_reset_n,
  // Watched ports
  input wire logic port_read,
  input wire logic [7:0] port_rdata,
  input wire logic core_drive0_select_n,
  input wire logic core_drive1_select_n,
  input wire logic core_motor0_enable_n,
  input wire logic core_motor1_enable_n,
  input wire floppy_cfg_pkg::core_cfg_s core_cfg,
  input wire logic core_write_protect_n,
  input wire logic write_protect_n,
  input wire logic drive0_select_n,
  input wire logic drive1_select_n,
  input wire logic motor0_enable_n,
  input wire logic motor1_enable_n,
  input wire logic [4:0] floppy_pin_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!(reset_n && standby_supply_por_n && host_bus_reset_n));
  tristate_off_a: assert property (core_cfg.outputs_tristate |-> floppy_pin_oe == 5'h00)
    else $error("pins driven while tristated");
  push_pull_a: assert property (!core_cfg.outputs_tristate && core_cfg.push_pull_driver |-> floppy_pin_oe == 5'h1F)
    else $error("push-pull pin not driven");
  open_drain_a: assert property (!core_cfg.outputs_tristate && !core_cfg.push_pull_driver |-> floppy_pin_oe[0] == !drive0_select_n)
    else $error("open drain drives high");
  drive_protect_a: assert property (!write_protect_n |=> !core_write_protect_n)
    else $error("drive protect not passed on");
  idle_protect_a: assert property (write_protect_n && core_drive0_select_n && core_drive1_select_n |=> core_write_protect_n)
    else $error("protect with no drive selected");
  select_idle_a: assert property (core_drive0_select_n && core_drive1_select_n |=> drive0_select_n && drive1_select_n)
    else $error("select pin active while idle");
  motor_idle_a: assert property (core_motor0_enable_n && core_motor1_enable_n |=> motor0_enable_n && motor1_enable_n)
    else $error("motor pin active while idle");
  rdata_hold_a: assert property (!port_read |=> $stable(port_rdata))
    else $error("read data moved without read");
  // Main scenarios
  cover property (core_cfg.outputs_tristate);
  cover property (core_cfg.push_pull_driver);
  cover property (!core_write_protect_n);
endmodule
bind floppy_logical_device_config floppy_cfg_sva u_sva (.*);

// [floppy_logical_device_config_tb.sv]
// Self-checking bench for the floppy configuration registers
`timescale 1ns/1ns
module floppy_logical_device_config_tb;
  logic sys_clk = 0, reset_n = 0, standby_supply_por_n = 1, host_bus_reset_n = 1;
  logic soft_reset = 0, device_selected = 1, port_write = 0, port_read = 0, port_data_sel = 0;
  logic core_drive0_select_n = 1, core_drive1_select_n = 1, core_motor0_enable_n = 1;
  logic core_motor1_enable_n = 1, core_density = 0, write_protect_n, core_write_protect_n;
  logic drive0_select_n, drive1_select_n, motor0_enable_n, motor1_enable_n, density;
  logic [7:0] port_wdata = 8'h00, port_rdata, v;
  logic [4:0] floppy_pin_oe;
  logic [7:0] modes [4] = '{8'h01, 8'h06, 8'h49, 8'h8C};
  floppy_cfg_pkg::core_cfg_s core_cfg;
  int fail_count = 0, comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  floppy_logical_device_config DUT (.*);
  floppy_drive_model drive (.*);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One strobe per call; the idle edge between calls keeps drivers apart
  task automatic wr(logic s, logic [7:0] d);
    @(posedge sys_clk);
    port_write <= 1;
    port_data_sel <= s;
    port_wdata <= d;
    @(posedge sys_clk);
    port_write <= 0;
  endtask
  task automatic wrr(logic [7:0] i, logic [7:0] d);
    wr(0, i);
    wr(1, d);
  endtask
  task automatic rd(logic [7:0] i, logic [7:0] e);
    wr(0, i);
    @(posedge sys_clk);
    port_read <= 1;
    port_data_sel <= 1;
    @(posedge sys_clk);
    port_read <= 0;
    @(negedge sys_clk);
    chk("port_rdata", e, port_rdata);
  endtask
  // Pins lag register writes by one cycle
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    rd(8'hF0, 8'h0E);
    rd(8'hF1, 8'h00);
    rd(8'h55, 8'h00);
    foreach (modes[i]) begin
      wrr(8'hF0, modes[i]);
      rd(8'hF0, modes[i]);
      v = modes[i];
      chk("core_cfg", {2'h0, v[0], v[1], v[3:2], v[6], v[7]}, core_cfg);
    end
    // Data write refused while deselected, then soft reset
    device_selected <= 0;
    wrr(8'hF0, 8'h00);
    device_selected <= 1;
    soft_reset <= 1;
    rd(8'hF0, 8'h8C);
    soft_reset <= 0;
    $display("register test done");
    wrr(8'hF0, 8'h50);
    core_drive0_select_n <= 0;
    core_motor0_enable_n <= 0;
    settle;
    chk("drive1_select_n", 8'h00, drive1_select_n);
    chk("motor1_enable_n", 8'h00, motor1_enable_n);
    chk("core_write_protect_n", 8'h00, core_write_protect_n);
    core_drive0_select_n <= 1;
    core_drive1_select_n <= 0;
    wrr(8'hF1, 8'h01);
    settle;
    chk("core_write_protect_n", 8'h00, core_write_protect_n);
    core_drive1_select_n <= 1;
    for (int i = 0; i < 4; i++) begin
      wrr(8'hF1, {4'h0, i[1:0], 2'h0});
      core_density <= i[0];
      settle;
      chk("density", {7'h00, i[1] ? !i[0] : i[0]}, density);
    end
    $display("pin test done");
    for (int i = 0; i < 3; i++) begin
      wrr(8'hF0, 8'hFF);
      {reset_n, standby_supply_por_n, host_bus_reset_n} <= ~(3'h1 << i);
      @(posedge sys_clk);
      {reset_n, standby_supply_por_n, host_bus_reset_n} <= 3'h7;
      rd(8'hF0, 8'h0E);
    end
    $display("reset test done");
    final_report;
  end
endmodule
